/* File: mdq_device.sv */
// Multiply/divide unit: six byte operand/result registers and a status.
// Assumes the host link of mdq_link_if, synchronous reset, one clock.
//
// How it works
// - Operand access while busy sets error flag
// - Status read after completion clears error flag
// - Overflow on product above FFFF or zero divisor
// - Overflow flag rewritten at every completion
// - Host writes low byte before high byte
// - Start only on register 5 ending sequence
// - Gaps between sequence writes keep progress
// - Division 32/16: write registers 0 to 5
// - Division 16/16: write registers 0,1,4,5
// - Multiply: write registers 0,4,1,5
// - Takes 17, 9 or 11 clock periods
// - Host leaves operand registers alone while busy
// - Host checks status before reading results
// - Division 32/16 results: quotient 0-3, remainder 4-5
// - Division 16/16 results: quotient 0-1, remainder 4-5
// - Product read from registers 0 to 3
// - Gaps between result reads are harmless
// - No idle or sleep during a calculation
// - Status bits 5 to 0 read zero
// - Unsigned 16x16 multiply, 32/16 divide
`timescale 1ns/1ps
`default_nettype none
module mdq_device (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Register link
  mdq_link_if.device LINK,
  // User side
  output logic CALC_BUSY
);

  // Write-order tracker states
  typedef enum logic [9:0] {
    SQ_NONE = 10'b0000000001,  // No sequence open
    SQ_W0 = 10'b0000000010,    // Register 0 written
    SQ_W01 = 10'b0000000100,   // 0,1
    SQ_W012 = 10'b0000001000,  // 0,1,2
    SQ_W0123 = 10'b0000010000, // 0,1,2,3
    SQ_W01234 = 10'b0000100000, // 0..4
    SQ_W014 = 10'b0001000000,  // 0,1,4
    SQ_W04 = 10'b0010000000,   // 0,4
    SQ_W041 = 10'b0100000000,  // 0,4,1
    SQ_BAD = 10'b1000000000    // Broken order, wait for register 0
  } mdq_seq_t;

  logic [7:0] opnd_r [0:5];   // Operand/result bytes
  mdq_seq_t seq_r;            // Write-order tracker
  mdq_seq_t seq_nxt;          // Tracker next value
  logic busy_r;               // Calculation in progress
  logic [4:0] cnt_r;          // Periods left in calculation
  mdq_pkg::mdq_op_t op_r;     // Operation being calculated
  logic err_r;                // Access error flag
  logic ov_r;                 // Overflow flag
  logic [7:0] rdata_r;        // Read answer
  logic start;                // Valid sequence closed this cycle
  mdq_pkg::mdq_op_t start_op; // Operation that it selects
  logic opnd_acc;             // Operand register touched
  logic done;                 // Last period of calculation
  logic [31:0] dividend;      // Dividend as stored
  logic [15:0] divisor;       // Divisor as stored
  logic [31:0] quot;          // Quotient
  logic [15:0] rem;           // Remainder
  logic [31:0] prod;          // Product

  assign opnd_acc = (LINK.wr | LINK.rd) && (LINK.addr <= mdq_pkg::REG_OPND5);
  assign done = busy_r && (cnt_r == 5'h01);

  // Operands as stored; frozen while busy so the result is stable
  assign divisor = {opnd_r[5], opnd_r[4]};
  assign dividend = (op_r == mdq_pkg::OP_DIV32) ?
    {opnd_r[3], opnd_r[2], opnd_r[1], opnd_r[0]} :
    {16'h0000, opnd_r[1], opnd_r[0]};
  // Unsigned arithmetic; a zero divisor is guarded so nothing divides by 0
  assign quot = (divisor == 16'h0000) ? 32'h00000000 :
    dividend / {16'h0000, divisor};
  assign rem = (divisor == 16'h0000) ? 16'h0000 :
    16'(dividend % {16'h0000, divisor});
  assign prod = {16'h0000, opnd_r[1], opnd_r[0]} *
    {16'h0000, opnd_r[5], opnd_r[4]};

  // Next tracker state; only operand writes outside a calculation count
  always_comb begin
    seq_nxt = seq_r;
    start = 1'b0;
    start_op = mdq_pkg::OP_DIV32;
    if (LINK.wr && !busy_r && LINK.addr <= mdq_pkg::REG_OPND5) begin
      if (LINK.addr == mdq_pkg::REG_OPND0) begin
        seq_nxt = SQ_W0;
      end else begin
        // Any write off the expected path breaks the sequence
        seq_nxt = SQ_BAD;
        case (seq_r)
          SQ_W0: begin
            if (LINK.addr == mdq_pkg::REG_OPND1) seq_nxt = SQ_W01;
            else if (LINK.addr == mdq_pkg::REG_OPND4) seq_nxt = SQ_W04;
          end
          SQ_W01: begin
            if (LINK.addr == mdq_pkg::REG_OPND2) seq_nxt = SQ_W012;
            else if (LINK.addr == mdq_pkg::REG_OPND4) seq_nxt = SQ_W014;
          end
          SQ_W012: begin
            if (LINK.addr == mdq_pkg::REG_OPND3) seq_nxt = SQ_W0123;
          end
          SQ_W0123: begin
            if (LINK.addr == mdq_pkg::REG_OPND4) seq_nxt = SQ_W01234;
          end
          SQ_W04: begin
            if (LINK.addr == mdq_pkg::REG_OPND1) seq_nxt = SQ_W041;
          end
          SQ_W01234: begin
            if (LINK.addr == mdq_pkg::REG_OPND5) begin
              start = 1'b1;
              start_op = mdq_pkg::OP_DIV32;
            end
          end
          SQ_W014: begin
            if (LINK.addr == mdq_pkg::REG_OPND5) begin
              start = 1'b1;
              start_op = mdq_pkg::OP_DIV16;
            end
          end
          SQ_W041: begin
            if (LINK.addr == mdq_pkg::REG_OPND5) begin
              start = 1'b1;
              start_op = mdq_pkg::OP_MUL;
            end
          end
          default: seq_nxt = SQ_BAD;
        endcase
        // A started operation closes the sequence
        if (start) seq_nxt = SQ_NONE;
      end
    end
  end

  // Tracker register; reads and idle cycles leave it alone
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) seq_r <= SQ_NONE;
    else seq_r <= seq_nxt;
  end

  // Calculation timer
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      busy_r <= 1'b0;
      cnt_r <= 5'h00;
      op_r <= mdq_pkg::OP_DIV32;
    end else if (start) begin
      busy_r <= 1'b1;
      cnt_r <= mdq_pkg::op_cycles(start_op);
      op_r <= start_op;
    end else if (busy_r) begin
      cnt_r <= 5'(cnt_r - 5'h01);
      if (done) busy_r <= 1'b0;
    end
  end

  // Operand bytes: host writes when idle, results at completion
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < 6; i++) opnd_r[i] <= mdq_pkg::OPND_RESET;
    end else if (done) begin
      case (op_r)
        mdq_pkg::OP_MUL: begin
          for (int i = 0; i < 4; i++) opnd_r[i] <= prod[i*8 +: 8];
        end
        default: begin
          // A zero divisor keeps the operands as they were
          if (divisor != 16'h0000) begin
            opnd_r[0] <= quot[7:0];
            opnd_r[1] <= quot[15:8];
            if (op_r == mdq_pkg::OP_DIV32) begin
              opnd_r[2] <= quot[23:16];
              opnd_r[3] <= quot[31:24];
            end
            opnd_r[4] <= rem[7:0];
            opnd_r[5] <= rem[15:8];
          end
        end
      endcase
    end else if (LINK.wr && !busy_r && LINK.addr <= mdq_pkg::REG_OPND5) begin
      // Writes during a calculation are dropped to protect the operands
      opnd_r[LINK.addr] <= LINK.wdata;
    end
  end

  // Overflow flag, rewritten by every completion
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ov_r <= mdq_pkg::STATUS_RESET[mdq_pkg::STAT_OV_BIT];
    end else if (done) begin
      if (op_r == mdq_pkg::OP_MUL) ov_r <= (prod > mdq_pkg::MUL_LIMIT);
      else ov_r <= (divisor == 16'h0000);
    end
  end

  // Error flag; a new bad access wins over the clearing read
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      err_r <= mdq_pkg::STATUS_RESET[mdq_pkg::STAT_ERR_BIT];
    end else if (opnd_acc && busy_r) begin
      err_r <= 1'b1;
    end else if (LINK.rd && LINK.addr == mdq_pkg::REG_STATUS && err_r &&
                 !busy_r) begin
      err_r <= 1'b0;
    end
  end

  // Read answer, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rdata_r <= 8'h00;
    end else if (LINK.rd) begin
      if (LINK.addr <= mdq_pkg::REG_OPND5) begin
        rdata_r <= opnd_r[LINK.addr];
      end else if (LINK.addr == mdq_pkg::REG_STATUS) begin
        rdata_r <= {err_r, ov_r, 6'h00};
      end else begin
        rdata_r <= 8'h00;
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign LINK.rdata = rdata_r;
  assign CALC_BUSY = busy_r;

endmodule : mdq_device
`default_nettype wire

/* File: mdq_pkg.sv */
// Shared constants, types and helpers of the multiply/divide unit link.
// Assumes one system clock; both ends compile against this package.
package mdq_pkg;

  // Register indices on the link address
  localparam logic [2:0] REG_OPND0 = 3'h0;
  localparam logic [2:0] REG_OPND1 = 3'h1;
  localparam logic [2:0] REG_OPND2 = 3'h2;
  localparam logic [2:0] REG_OPND3 = 3'h3;
  localparam logic [2:0] REG_OPND4 = 3'h4;
  localparam logic [2:0] REG_OPND5 = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;

  // Status register layout and reset value
  localparam int STAT_ERR_BIT = 7;
  localparam int STAT_OV_BIT = 6;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] OPND_RESET = 8'h00;

  // Largest product that does not overflow
  localparam logic [31:0] MUL_LIMIT = 32'h0000FFFF;

  // Calculation times in system clock periods, one clock per period
  localparam int DIV32_PERIODS = 17;
  localparam int DIV16_PERIODS = 9;
  localparam int MUL_PERIODS = 11;
  localparam int CLK_PER_PERIOD = 1;
  localparam logic [4:0] DIV32_CYCLES = 5'(DIV32_PERIODS * CLK_PER_PERIOD);
  localparam logic [4:0] DIV16_CYCLES = 5'(DIV16_PERIODS * CLK_PER_PERIOD);
  localparam logic [4:0] MUL_CYCLES = 5'(MUL_PERIODS * CLK_PER_PERIOD);

  // Operation kinds, one-hot
  typedef enum logic [2:0] {
    OP_DIV32 = 3'b001,
    OP_DIV16 = 3'b010,
    OP_MUL = 3'b100
  } mdq_op_t;

  // Calculation time of an operation
  function automatic logic [4:0] op_cycles(input mdq_op_t op);
    case (op)
      OP_DIV32: op_cycles = DIV32_CYCLES;
      OP_DIV16: op_cycles = DIV16_CYCLES;
      default: op_cycles = MUL_CYCLES;
    endcase
  endfunction : op_cycles

  // Number of bytes written, and read back, for an operation
  function automatic logic [2:0] op_len(input mdq_op_t op);
    op_len = (op == OP_DIV32) ? 3'h6 : 3'h4;
  endfunction : op_len

  // Register written at a given step of the write order
  function automatic logic [2:0] wr_addr(input mdq_op_t op,
                                         input logic [2:0] step);
    if (op == OP_MUL) begin
      case (step)
        3'h0: wr_addr = REG_OPND0;
        3'h1: wr_addr = REG_OPND4;
        3'h2: wr_addr = REG_OPND1;
        default: wr_addr = REG_OPND5;
      endcase
    end else begin
      wr_addr = rd_addr(op, step);
    end
  endfunction : wr_addr

  // Register read at a given step of the read order
  function automatic logic [2:0] rd_addr(input mdq_op_t op,
                                         input logic [2:0] step);
    if (op == OP_DIV16 && step >= 3'h2) begin
      rd_addr = 3'(step + 3'h2);
    end else begin
      rd_addr = step;
    end
  endfunction : rd_addr

endpackage : mdq_pkg

/* File: mdq_link_if.sv */
// Register link between the processor-side controller and the unit.
// Assumes one clock; the host drives strobes, the device answers data.
`timescale 1ns/1ps
`default_nettype none
interface mdq_link_if;
  logic [2:0] addr;   // Register index
  logic [7:0] wdata;  // Write data
  logic wr;           // Write strobe, one cycle
  logic rd;           // Read strobe, one cycle
  logic [7:0] rdata;  // Read data, cycle after rd

  // Controller end
  modport host (output addr, output wdata, output wr, output rd,
                input rdata);
  // Arithmetic unit end
  modport device (input addr, input wdata, input wr, input rd,
                  output rdata);
endinterface : mdq_link_if
`default_nettype wire

/* File: mdq_host.sv */
// Controller end: runs one operation over the register link per command.
// Assumes mdq_link_if towards the unit, synchronous reset, one clock.
`timescale 1ns/1ps
`default_nettype none
module mdq_host (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Register link
  mdq_link_if.host LINK,
  // Command
  input wire logic CMD_START,
  input wire logic [2:0] CMD_OP,
  input wire logic [31:0] CMD_A,
  input wire logic [15:0] CMD_B,
  // Result
  output logic BUSY,
  output logic DONE,
  output logic [31:0] RES_Q,
  output logic [15:0] RES_R,
  output logic RES_OV,
  output logic RES_ERR
);

  // Sequencer states
  typedef enum logic [6:0] {
    H_IDLE = 7'b0000001, // Waiting for a command
    H_WR = 7'b0000010,   // Writing operands in order
    H_WAIT = 7'b0000100, // Calculation time
    H_STAT = 7'b0001000, // Status read strobe
    H_STCAP = 7'b0010000, // Status answer
    H_RD = 7'b0100000,   // Result read strobe
    H_RDCAP = 7'b1000000 // Result answer
  } mdq_hst_t;

  mdq_hst_t st_r;           // Sequencer state
  mdq_pkg::mdq_op_t op_r;   // Operation in hand
  logic [47:0] opnd_r;      // Operand bytes by register index
  logic [47:0] res_r;       // Result bytes by register index
  logic [2:0] step_r;       // Byte step
  logic [4:0] wait_r;       // Wait counter
  logic [2:0] addr_r;       // Link address
  logic [7:0] wdata_r;      // Link write data
  logic wr_r;               // Link write strobe
  logic rd_r;               // Link read strobe
  logic done_r;             // Completion pulse
  logic ov_r;               // Overflow seen
  logic err_r;              // Access error seen
  logic [2:0] last;         // Last step of the current order

  assign last = 3'(mdq_pkg::op_len(op_r) - 3'h1);

  // Sequencer and link drive
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_r <= H_IDLE;
      op_r <= mdq_pkg::OP_DIV32;
      opnd_r <= 48'h000000000000;
      res_r <= 48'h000000000000;
      step_r <= 3'h0;
      wait_r <= 5'h00;
      addr_r <= 3'h0;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
      ov_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
      case (st_r)
        H_IDLE: begin
          // Unknown operation codes are ignored
          if (CMD_START && (CMD_OP == mdq_pkg::OP_DIV32 ||
              CMD_OP == mdq_pkg::OP_DIV16 || CMD_OP == mdq_pkg::OP_MUL)) begin
            op_r <= mdq_pkg::mdq_op_t'(CMD_OP);
            opnd_r <= {CMD_B, CMD_A};
            res_r <= 48'h000000000000;
            step_r <= 3'h0;
            st_r <= H_WR;
          end
        end
        H_WR: begin
          // Low byte of each operand always goes first
          addr_r <= mdq_pkg::wr_addr(op_r, step_r);
          wdata_r <= opnd_r[mdq_pkg::wr_addr(op_r, step_r)*8 +: 8];
          wr_r <= 1'b1;
          step_r <= 3'(step_r + 3'h1);
          if (step_r == last) begin
            wait_r <= mdq_pkg::op_cycles(op_r);
            st_r <= H_WAIT;
          end
        end
        H_WAIT: begin
          // Stay off the link for the whole calculation, plus one cycle
          wait_r <= 5'(wait_r - 5'h01);
          if (wait_r == 5'h00) st_r <= H_STAT;
        end
        H_STAT: begin
          addr_r <= mdq_pkg::REG_STATUS;
          rd_r <= 1'b1;
          st_r <= H_STCAP;
        end
        H_STCAP: begin
          // Status answer is on the link once the read strobe has dropped
          if (rd_r) begin
            // Strobe still going out this cycle; answer comes next
          end else begin
            ov_r <= LINK.rdata[mdq_pkg::STAT_OV_BIT];
            err_r <= LINK.rdata[mdq_pkg::STAT_ERR_BIT];
            step_r <= 3'h0;
            if (LINK.rdata[mdq_pkg::STAT_OV_BIT] ||
                LINK.rdata[mdq_pkg::STAT_ERR_BIT]) begin
              done_r <= 1'b1;
              st_r <= H_IDLE;
            end else begin
              st_r <= H_RD;
            end
          end
        end
        H_RD: begin
          addr_r <= mdq_pkg::rd_addr(op_r, step_r);
          rd_r <= 1'b1;
          st_r <= H_RDCAP;
        end
        H_RDCAP: begin
          if (!rd_r) begin
            res_r[addr_r*8 +: 8] <= LINK.rdata;
            step_r <= 3'(step_r + 3'h1);
            if (step_r == last) begin
              done_r <= 1'b1;
              st_r <= H_IDLE;
            end else begin
              st_r <= H_RD;
            end
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign LINK.addr = addr_r;
  assign LINK.wdata = wdata_r;
  assign LINK.wr = wr_r;
  assign LINK.rd = rd_r;
  assign BUSY = (st_r != H_IDLE);
  assign DONE = done_r;
  assign RES_Q = res_r[31:0];
  assign RES_R = res_r[47:32];
  assign RES_OV = ov_r;
  assign RES_ERR = err_r;

endmodule : mdq_host
`default_nettype wire

/* File: mdq_chk.sv */
// Link checker: watches strobes, read data and busy of one unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module mdq_chk (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Link
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Unit state
  input wire logic CALC_BUSY
);
  logic [3:0] seq_r; // Write order progress, 0 = none
  logic [3:0] seq_nxt;
  logic [4:0] len_r; // Busy length owed by the running operation
  logic [4:0] cnt_r; // Busy cycles seen so far
  logic err_r; // Reference copy of the error flag
  logic acc; // Operand register access
  logic go; // Write that completes a valid order
  logic stat_rd; // Status register read

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  assign acc = (wr || rd) && (addr <= 3'h5);
  assign stat_rd = rd && (addr == 3'h6);
  assign go = wr && !CALC_BUSY && (addr == 3'h5) &&
              (seq_r == 4'h5 || seq_r == 4'h6 || seq_r == 4'h8);

  // Order tracker; states 5, 6 and 8 await the final write
  always_comb begin
    seq_nxt = seq_r;
    // Writes while busy are dropped, so they leave progress alone
    if (wr && !CALC_BUSY && addr <= 3'h5) begin
      case ({seq_r, addr})
        7'h09: seq_nxt = 4'h2; // 0,1
        7'h0C: seq_nxt = 4'h7; // 0,4
        7'h12: seq_nxt = 4'h3; // 0,1,2
        7'h14: seq_nxt = 4'h6; // 0,1,4
        7'h1B: seq_nxt = 4'h4; // 0,1,2,3
        7'h24: seq_nxt = 4'h5; // 0,1,2,3,4
        7'h39: seq_nxt = 4'h8; // 0,4,1
        default: seq_nxt = (addr == 3'h0) ? 4'h1 : 4'h0;
      endcase
    end
  end

  // Tracker state
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) seq_r <= 4'h0;
    else seq_r <= seq_nxt;
  end

  // Busy length chosen by the order that started it
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) len_r <= 5'h00;
    else if (go) len_r <= (seq_r == 4'h5) ? mdq_pkg::DIV32_CYCLES :
                          (seq_r == 4'h6) ? mdq_pkg::DIV16_CYCLES :
                          mdq_pkg::MUL_CYCLES;
  end

  // Counts busy cycles; reads N in the cycle busy drops
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) cnt_r <= 5'h00;
    else cnt_r <= CALC_BUSY ? cnt_r + 5'h01 : 5'h00;
  end

  // Error flag: set wins, clear only on an idle status read
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) err_r <= 1'b0;
    else if (acc && CALC_BUSY) err_r <= 1'b1;
    else if (stat_rd && !CALC_BUSY) err_r <= 1'b0;
  end

  // Valid order, then busy raised one edge later
  sequence s_start;
    go ##1 $rose(CALC_BUSY);
  endsequence
  // Shortest calculation still covers eight cycles
  sequence s_hold;
    CALC_BUSY [*8];
  endsequence

  busy_start_a: assert property (go |=> $rose(CALC_BUSY))
    else $error("valid order did not start the unit");
  false_start_a: assert property ($rose(CALC_BUSY) |-> $past(go))
    else $error("unit started without a valid order");
  busy_min_a: assert property (s_start |-> s_hold)
    else $error("calculation ended too early");
  busy_len_a: assert property ($fell(CALC_BUSY) |-> cnt_r == len_r)
    else $error("calculation length wrong");
  err_flag_a: assert property ($past(stat_rd) |->
    rdata[7] == $past(err_r))
    else $error("error flag wrong");
  stat_low_a: assert property ($past(stat_rd) |-> rdata[5:0] == 6'h00)
    else $error("status low bits not zero");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside answer cycle");
  host_quiet_a: assert property (CALC_BUSY |-> !acc)
    else $error("controller touched operands while busy");
  strobe_excl_a: assert property (!(wr && rd))
    else $error("both strobes high");
endmodule : mdq_chk
`default_nettype wire

/* File: multiply_divide_unit_bench.sv */
// Bench: controller and unit joined by a link, plus a lone unit.
// Assumes the design files compiled first; the lone unit is bench-driven.
`timescale 1ns/1ps
`default_nettype none
module multiply_divide_unit_bench;
  logic sys_clk;
  logic sys_rst;
  logic cmd_start;
  logic [2:0] cmd_op;
  logic [31:0] cmd_a;
  logic [15:0] cmd_b;
  logic busy, done, res_ov, res_err, calc_busy, calc_busy2;
  logic [31:0] res_q;
  logic [15:0] res_r;
  logic [7:0] d; // Last byte read on the second link
  logic [2:0] wq_a[$], rq[$]; // Addresses seen on the first link
  logic [7:0] wq_d[$]; // Write data seen on the first link
  int fails;
  int num_checks;

  mdq_link_if lnk();
  mdq_link_if lnk2(); // Bench plays a misbehaving controller here
  mdq_host u_mdq_host (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LINK(lnk),
    .CMD_START(cmd_start), .CMD_OP(cmd_op), .CMD_A(cmd_a), .CMD_B(cmd_b),
    .BUSY(busy), .DONE(done), .RES_Q(res_q), .RES_R(res_r),
    .RES_OV(res_ov), .RES_ERR(res_err));
  mdq_device u_mdq_device (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
    .LINK(lnk), .CALC_BUSY(calc_busy));
  mdq_device u_mdq_device_f (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
    .LINK(lnk2), .CALC_BUSY(calc_busy2));
  mdq_chk u_mdq_chk (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
    .addr(lnk.addr), .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd),
    .rdata(lnk.rdata), .CALC_BUSY(calc_busy));

  // Free-running 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Record every strobe on the first link
  always @(posedge sys_clk) begin
    if (lnk.wr === 1'b1) begin
      wq_a.push_back(lnk.addr);
      wq_d.push_back(lnk.wdata);
    end
    if (lnk.rd === 1'b1) rq.push_back(lnk.addr);
  end

  // Counts a comparison and passes its outcome through
  function automatic bit bad(input bit c);
    num_checks++;
    return c;
  endfunction : bad

  task err(input string m);
    fails++;
    $display("ERROR at %0t: %s", $time, m);
  endtask : err

  // One command through the controller, then judge link and results
  task run_op(input mdq_pkg::mdq_op_t op, input logic [31:0] a,
              input logic [15:0] b);
    logic [23:0] wa; // Write addresses, one nibble per step
    logic [47:0] wd; // Write bytes, one per step
    logic [27:0] ra; // Status read, then result addresses
    logic [31:0] eq;
    logic [15:0] er;
    logic ov;
    int n, k;
    ov = (b == 16'h0000);
    er = 16'h0000;
    case (op)
      mdq_pkg::OP_DIV32: begin
        wa = 24'h543210;
        wd = {b, a};
        ra = 28'h5432106;
        n = 6;
        eq = ov ? 32'h0 : a / b;
        er = ov ? 16'h0 : 16'(a % b);
      end
      mdq_pkg::OP_DIV16: begin
        wa = 24'h005410;
        wd = {16'h0000, b, a[15:0]};
        ra = 28'h0054106;
        n = 4;
        eq = ov ? 32'h0 : {16'h0000, a[15:0] / b};
        er = ov ? 16'h0 : a[15:0] % b;
      end
      default: begin
        wa = 24'h005140;
        wd = {16'h0000, b[15:8], a[15:8], b[7:0], a[7:0]};
        ra = 28'h0032106;
        n = 4;
        eq = a[15:0] * b;
        ov = (eq > 32'h0000FFFF);
      end
    endcase
    wq_a.delete();
    wq_d.delete();
    rq.delete();
    @(posedge sys_clk);
    cmd_op <= op;
    cmd_a <= a;
    cmd_b <= b;
    cmd_start <= 1'b1;
    @(posedge sys_clk);
    cmd_start <= 1'b0;
    // Completion is bounded well above the longest walk
    for (k = 0; k < 200 && done !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (bad(done !== 1'b1)) err("no completion");
    if (bad(wq_a.size() != n)) err("write count");
    for (int i = 0; i < n && i < wq_a.size(); i++) begin
      if (bad(wq_a[i] !== wa[4*i+:3])) err("write order");
      if (bad(wq_d[i] !== wd[8*i+:8])) err("write byte");
    end
    k = ov ? 1 : n + 1;
    if (bad(rq.size() != k)) err("read count");
    for (int i = 0; i < k && i < rq.size(); i++) begin
      if (bad(rq[i] !== ra[4*i+:3])) err("read order");
    end
    if (bad(res_ov !== ov)) err("overflow");
    if (bad(res_err !== 1'b0)) err("error flag");
    if (!ov && bad(res_q !== eq)) err("quotient or product");
    if (!ov && bad(res_r !== er)) err("remainder");
  endtask : run_op

  // Write on the second link; data inverted once released
  task wr2(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    lnk2.addr <= a;
    lnk2.wdata <= v;
    lnk2.wr <= 1'b1;
    @(posedge sys_clk);
    lnk2.wr <= 1'b0;
    lnk2.wdata <= ~v;
    #1; // Let the taking edge settle
  endtask : wr2

  // Read on the second link and compare the answer byte
  task rchk2(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    lnk2.addr <= a;
    lnk2.rd <= 1'b1;
    @(posedge sys_clk);
    lnk2.rd <= 1'b0;
    #1;
    d = lnk2.rdata;
    if (bad(d !== e)) err($sformatf("reg %0d read %h not %h", a, d, e));
  endtask : rchk2

  task seq2(input logic [23:0] wa, input logic [47:0] wd, input int n);
    for (int i = 0; i < n; i++) wr2(wa[4*i+:3], wd[8*i+:8]);
  endtask : seq2

  task wait_idle2;
    for (int i = 0; i < 40 && calc_busy2 !== 1'b0; i++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : wait_idle2

  task t_host_ops;
    run_op(mdq_pkg::OP_DIV32, 32'h12345678, 16'h1234);
    run_op(mdq_pkg::OP_DIV16, 32'h0000FFFF, 16'h0007);
    run_op(mdq_pkg::OP_MUL, 32'h0000FFFF, 16'h0001);
    run_op(mdq_pkg::OP_MUL, 32'h00000100, 16'h0100);
    run_op(mdq_pkg::OP_MUL, 32'h000000FF, 16'h0101);
    run_op(mdq_pkg::OP_DIV32, 32'h00001234, 16'h0000);
    run_op(mdq_pkg::OP_DIV16, 32'h00000005, 16'h0009);
    $display("test host_ops done");
  endtask : t_host_ops

  // A code that is not one-hot must start nothing
  task t_bad_cmd;
    wq_a.delete();
    @(posedge sys_clk);
    cmd_op <= 3'h3;
    cmd_start <= 1'b1;
    repeat (10) @(posedge sys_clk);
    cmd_start <= 1'b0;
    #1;
    if (bad(busy !== 1'b0 || wq_a.size() != 0)) err("bad command ran");
    $display("test bad_cmd done");
  endtask : t_bad_cmd

  // Access while busy sets the error flag; results survive it
  task t_busy_err;
    wr2(3'h0, 8'h64);
    repeat (3) @(posedge sys_clk);
    rchk2(3'h6, 8'h00);
    seq2(24'h000541, 48'h000000000700, 3);
    if (bad(calc_busy2 !== 1'b1)) err("div16 not started");
    wr2(3'h0, 8'hAA);
    rchk2(3'h6, 8'h80);
    wait_idle2();
    rchk2(3'h6, 8'h80);
    rchk2(3'h6, 8'h00);
    rchk2(3'h0, 8'h0E);
    repeat (2) @(posedge sys_clk);
    rchk2(3'h1, 8'h00);
    rchk2(3'h4, 8'h02);
    rchk2(3'h5, 8'h00);
    $display("test busy_err done");
  endtask : t_busy_err

  // Broken orders start nothing until register 0 restarts them
  task t_bad_order;
    seq2(24'h000510, 48'h000000000001, 3);
    if (bad(calc_busy2 !== 1'b0)) err("gap order started");
    seq2(24'h000541, 48'h000000000000, 3);
    if (bad(calc_busy2 !== 1'b0)) err("dead order started");
    seq2(24'h005140, 48'h000000000503, 4);
    if (bad(calc_busy2 !== 1'b1)) err("mul not started");
    wait_idle2();
    rchk2(3'h6, 8'h00);
    for (int i = 0; i < 4; i++) rchk2(3'(i), i == 0 ? 8'h0F : 8'h00);
    seq2(24'h005140, 48'h000001010000, 4);
    wait_idle2();
    rchk2(3'h6, 8'h40);
    $display("test bad_order done");
  endtask : t_bad_order

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // Main sequence; first request one edge after reset is seen low
  initial begin
    fails = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    cmd_start = 1'b0;
    cmd_op = 3'h0;
    cmd_a = 32'h0;
    cmd_b = 16'h0;
    lnk2.addr = 3'h0;
    lnk2.wdata = 8'h00;
    lnk2.wr = 1'b0;
    lnk2.rd = 1'b0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_host_ops();
    t_bad_cmd();
    t_busy_err();
    t_bad_order();
    summarize();
  end

  // Tests need about 350 cycles; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : multiply_divide_unit_bench
`default_nettype wire
